// ==== logic/dlb_lane_order.sv ====
`timescale 1ns/1ps
module dlb_lane_order
   import dlb_pkg::*;
#(
   parameter int unsigned P_LEN_W   = DLB_LEN_W,
   parameter bit          P_PIO8_EN = 1'b0
) (
   // Clock and reset.
   input  logic               i_clk,
   input  logic               i_reset_n,
   // Block set-up from the device core.
   input  logic               i_blk_start,
   input  logic [P_LEN_W-1:0] i_blk_len,
   input  dlb_mode_t          i_blk_mode,
   input  logic               i_blk_to_host,
   input  logic               i_blk_ascii,
   // Byte stream towards the host.
   input  logic [7:0]         i_tx_byte,
   input  logic               i_tx_valid,
   output logic               o_tx_ready,
   // Byte stream from the host.
   output logic [7:0]         o_rx_byte,
   output logic               o_rx_valid,
   // Block status.
   output logic               o_done,
   output logic               o_err,
   output logic [1:0]         o_err_code,
   // Host side pins.
   input  logic               i_strobe,
   input  logic               i_dma_ack_n,
   output logic               o_dma_request,
   output logic               o_device_occupied_flag,
   output logic               o_transfer_request_flag,
   input  logic [15:0]        i_parallel_data_lines,
   output logic [15:0]        o_parallel_data_lines,
   output logic               o_parallel_data_lines_oe
);

   dlb_state_t         state_r, state_nxt;
   dlb_mode_t          mode_r;
   logic               to_host_r, ascii_r, wrdy_r, wrdy_nxt;
   logic [P_LEN_W-1:0] remain_r, need_r, need_nxt, rem_a, xcnt;
   logic [1:0]         stg_cnt_r, cnt_a, bb_r;
   logic [7:0]         b0_r, b1_r, b0_nxt, b1_nxt, b_in, pend_byte_r, first_b, second_b;
   logic [15:0]        map_word;
   logic               tx_take, xfer, xfer_tx, xfer_rx, full_a, start_ok, start_bad;
   logic               tx_dir_nxt, pend_r, bad_char, burst_end;
   logic               tx_ready_r, rx_valid_r, done_r, err_r, dmarq_r, occ_r, req_r, oe_r;
   logic [1:0]         err_code_r;
   logic [7:0]         rx_byte_r;
   logic [15:0]        pdl_out_r;

   dlb_lane_map u_map (
      .i_b0     (b0_nxt),
      .i_b1     (b1_nxt),
      .i_pio8   (mode_r == DLB_MODE_PIO8),
      .i_ascii  (ascii_r),
      .i_word   (i_parallel_data_lines),
      .o_word   (map_word),
      .o_first  (first_b),
      .o_second (second_b)
   );

   // Start checks: zero length, a disabled narrow mode and a one-byte DMA block are refused.
   always_comb begin
      start_bad = i_blk_start && (state_r == DLB_ST_IDLE) &&
                  ((i_blk_len == '0) ||
                   ((i_blk_mode == DLB_MODE_PIO8) && !P_PIO8_EN) ||
                   ((i_blk_mode == DLB_MODE_DMA) && (i_blk_len < P_LEN_W'(2))));
      start_ok  = i_blk_start && (state_r == DLB_ST_IDLE) && !start_bad;
   end

   // Transfer qualification, byte accounting and word assembly.
   always_comb begin
      tx_take = i_tx_valid && tx_ready_r;
      xfer    = i_strobe &&
                (((state_r == DLB_ST_PIO) && !occ_r && req_r) ||
                 ((state_r == DLB_ST_DBUR) && !i_dma_ack_n && (!to_host_r || wrdy_r)));
      xfer_tx = xfer && to_host_r;
      xfer_rx = xfer && !to_host_r;
      if (to_host_r) begin
         xcnt = P_LEN_W'(stg_cnt_r);
      end else if ((mode_r == DLB_MODE_PIO8) || (remain_r == P_LEN_W'(1))) begin
         xcnt = P_LEN_W'(1);
      end else begin
         xcnt = P_LEN_W'(2);
      end
      rem_a      = xfer ? remain_r - xcnt : remain_r;
      cnt_a      = xfer_tx ? 2'd0 : stg_cnt_r + {1'b0, tx_take};
      need_nxt   = start_ok ? (i_blk_to_host ? i_blk_len : '0) : need_r - P_LEN_W'(tx_take);
      full_a     = (cnt_a == 2'd2) ||
                   ((cnt_a == 2'd1) && ((mode_r == DLB_MODE_PIO8) || (need_nxt == '0)));
      wrdy_nxt   = !xfer_tx && (wrdy_r || (tx_take && full_a));
      tx_dir_nxt = start_ok ? i_blk_to_host : to_host_r;
      bad_char   = ascii_r && !dlb_is_print(i_tx_byte);
      b_in       = bad_char ? DLB_ASCII_FILL : i_tx_byte;
      b0_nxt     = b0_r;
      b1_nxt     = b1_r;
      if (tx_take && (stg_cnt_r == 2'd0)) begin
         b0_nxt = b_in;
         b1_nxt = DLB_RST_BYTE;
      end else if (tx_take) begin
         b1_nxt = b_in;
      end
      burst_end = (state_r == DLB_ST_DBUR) && i_dma_ack_n;
   end

   // Sequencer: programmed blocks end on the last byte, DMA blocks on the acknowledge release.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         DLB_ST_IDLE: begin
            if (start_ok) begin
               state_nxt = (i_blk_mode == DLB_MODE_DMA) ? DLB_ST_DREQ : DLB_ST_PIO;
            end
         end
         DLB_ST_PIO: begin
            if (rem_a == '0) begin
               state_nxt = DLB_ST_IDLE;
            end
         end
         DLB_ST_DREQ: begin
            if (!i_dma_ack_n) begin
               state_nxt = DLB_ST_DBUR;
            end
         end
         DLB_ST_DBUR: begin
            if (i_dma_ack_n) begin
               state_nxt = (remain_r == '0) ? DLB_ST_IDLE : DLB_ST_DREQ;
            end
         end
      endcase
   end

   // Block context, loaded at start.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r   <= DLB_ST_IDLE;
         mode_r    <= DLB_MODE_PIO16;
         to_host_r <= 1'b0;
         ascii_r   <= 1'b0;
         remain_r  <= '0;
      end else begin
         state_r <= state_nxt;
         if (start_ok) begin
            mode_r    <= i_blk_mode;
            to_host_r <= i_blk_to_host;
            ascii_r   <= i_blk_ascii;
            remain_r  <= i_blk_len;
         end else begin
            remain_r <= rem_a;
         end
      end
   end

   // Outgoing word staging and the byte stream handshake.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         need_r     <= '0;
         stg_cnt_r  <= 2'd0;
         b0_r       <= DLB_RST_BYTE;
         b1_r       <= DLB_RST_BYTE;
         wrdy_r     <= 1'b0;
         tx_ready_r <= 1'b0;
      end else begin
         need_r     <= need_nxt;
         stg_cnt_r  <= cnt_a;
         b0_r       <= b0_nxt;
         b1_r       <= b1_nxt;
         wrdy_r     <= wrdy_nxt;
         tx_ready_r <= (state_nxt != DLB_ST_IDLE) && tx_dir_nxt && !wrdy_nxt &&
                       (need_nxt != '0);
      end
   end

   // Incoming word split into bytes; the second byte follows one cycle later.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rx_byte_r   <= DLB_RST_BYTE;
         rx_valid_r  <= 1'b0;
         pend_r      <= 1'b0;
         pend_byte_r <= DLB_RST_BYTE;
      end else begin
         rx_valid_r <= xfer_rx || pend_r;
         pend_r     <= xfer_rx && (xcnt == P_LEN_W'(2));
         if (xfer_rx) begin
            rx_byte_r   <= first_b;
            pend_byte_r <= second_b;
         end else if (pend_r) begin
            rx_byte_r <= pend_byte_r;
         end
      end
   end

   // Host pins: data drive, request and status flags.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pdl_out_r <= DLB_RST_WORD;
         oe_r      <= 1'b0;
         dmarq_r   <= 1'b0;
         req_r     <= 1'b0;
         occ_r     <= 1'b0;
      end else begin
         pdl_out_r <= map_word;
         oe_r      <= tx_dir_nxt && wrdy_nxt &&
                      ((state_nxt == DLB_ST_PIO) || (state_nxt == DLB_ST_DBUR));
         dmarq_r   <= ((state_nxt == DLB_ST_DREQ) || (state_nxt == DLB_ST_DBUR)) &&
                      (rem_a != '0) && (!tx_dir_nxt || wrdy_nxt);
         req_r     <= (state_nxt == DLB_ST_PIO) && (!tx_dir_nxt || wrdy_nxt);
         occ_r     <= (state_nxt != DLB_ST_IDLE) &&
                      !((state_nxt == DLB_ST_PIO) && (!tx_dir_nxt || wrdy_nxt));
      end
   end

   // Burst byte count, saturating at two, cleared whenever no burst is open.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bb_r <= 2'd0;
      end else if (state_r != DLB_ST_DBUR) begin
         bb_r <= 2'd0;
      end else if (xfer) begin
         bb_r <= ((xcnt >= P_LEN_W'(2)) || (bb_r != 2'd0)) ? 2'd2 : 2'd1;
      end
   end

   // Completion and error pulses.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         done_r     <= 1'b0;
         err_r      <= 1'b0;
         err_code_r <= DLB_ERR_NONE;
      end else begin
         done_r <= (state_r != DLB_ST_IDLE) && (state_nxt == DLB_ST_IDLE);
         err_r  <= start_bad || (burst_end && (bb_r < 2'd2)) || (tx_take && bad_char);
         if (start_bad) begin
            err_code_r <= DLB_ERR_MODE;
         end else if (burst_end && (bb_r < 2'd2)) begin
            err_code_r <= DLB_ERR_SHORT;
         end else if (tx_take && bad_char) begin
            err_code_r <= DLB_ERR_ASCII;
         end else begin
            err_code_r <= DLB_ERR_NONE;
         end
      end
   end

   // Every output is a flip-flop.
   assign o_tx_ready               = tx_ready_r;
   assign o_rx_byte                = rx_byte_r;
   assign o_rx_valid               = rx_valid_r;
   assign o_done                   = done_r;
   assign o_err                    = err_r;
   assign o_err_code               = err_code_r;
   assign o_dma_request            = dmarq_r;
   assign o_device_occupied_flag   = occ_r;
   assign o_transfer_request_flag  = req_r;
   assign o_parallel_data_lines    = pdl_out_r;
   assign o_parallel_data_lines_oe = oe_r;

   // Checks run on the module clock and rest while reset is low.
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   AST_PIO_FLAGS: assert property (i_strobe && (state_r == DLB_ST_PIO) &&
      (occ_r || !req_r) |=> remain_r == $past(remain_r))
      else $error("programmed word moved with wrong status flags");
   AST_PIO8_GATE: assert property (i_blk_start && (state_r == DLB_ST_IDLE) &&
      (i_blk_mode == DLB_MODE_PIO8) && !P_PIO8_EN |=> err_r && (state_r == DLB_ST_IDLE))
      else $error("disabled narrow mode was accepted");
   AST_EMPTY_BLOCK: assert property (i_blk_start && (state_r == DLB_ST_IDLE) &&
      (i_blk_len == '0) |=> err_r && (err_code_r == DLB_ERR_MODE))
      else $error("empty block was accepted");
   AST_DMA_ACK: assert property (xfer && (mode_r == DLB_MODE_DMA) |->
      !i_dma_ack_n && ($past(dmarq_r) || ($past(state_r) == DLB_ST_DBUR)))
      else $error("DMA data moved outside an acknowledge");
   AST_DMA_WIDE: assert property (xfer_rx && (mode_r == DLB_MODE_DMA) &&
      (remain_r >= P_LEN_W'(2)) |=> rx_valid_r ##1 rx_valid_r)
      else $error("DMA word did not yield two bytes");
   AST_SHORT_BURST: assert property (burst_end && (bb_r == 2'd0) |=>
      err_r && (err_code_r == DLB_ERR_SHORT))
      else $error("short burst not reported");
   AST_BYTE_COUNT: assert property ((state_r != DLB_ST_IDLE) && xfer |=>
      remain_r == $past(remain_r) - $past(xcnt))
      else $error("byte count did not follow the transfer");
   AST_LANES16: assert property (oe_r && (mode_r != DLB_MODE_PIO8) && !ascii_r |->
      o_parallel_data_lines == {b1_r, b0_r})
      else $error("wide lane order wrong");
   AST_LANES8: assert property (oe_r && (mode_r == DLB_MODE_PIO8) |->
      (o_parallel_data_lines == {DLB_RST_BYTE, b0_r}) && (stg_cnt_r == 2'd1))
      else $error("narrow lane order wrong");
   AST_ASCII_RANGE: assert property (oe_r && ascii_r |-> dlb_is_print(b0_r) &&
      (dlb_is_print(b1_r) || (b1_r == DLB_RST_BYTE)))
      else $error("text byte outside printable range");
   AST_ASCII_ORDER: assert property (xfer_rx && ascii_r && (mode_r != DLB_MODE_PIO8) |=>
      rx_valid_r && (rx_byte_r == $past(i_parallel_data_lines[15:8])))
      else $error("text lane order wrong");
   AST_ACK_LOW: assert property ((state_r == DLB_ST_DREQ) && !i_dma_ack_n |=>
      state_r == DLB_ST_DBUR)
      else $error("low acknowledge did not open a burst");

   COV_PIO_BLOCK: cover property ((state_r == DLB_ST_PIO) ##[1:200] done_r);
   COV_DMA_TWO_BURSTS: cover property ((state_r == DLB_ST_DBUR) ##1 (state_r == DLB_ST_DREQ)
      ##[1:200] (state_r == DLB_ST_DBUR));
   COV_ASCII_RX: cover property (xfer_rx && ascii_r);
   COV_SHORT: cover property (err_r && (err_code_r == DLB_ERR_SHORT));
   COV_PIO8: cover property (oe_r && (mode_r == DLB_MODE_PIO8));

endmodule

// ==== logic/dlb_pkg.sv ====
package dlb_pkg;

   // Widths of one lane, one bus word and the block length counter.
   localparam int unsigned DLB_BYTE_W = 8;
   localparam int unsigned DLB_WORD_W = 16;
   localparam int unsigned DLB_LEN_W  = 16;

   // Printable range for text fields, and the byte that replaces anything outside it.
   localparam logic [7:0] DLB_ASCII_MIN  = 8'h20;
   localparam logic [7:0] DLB_ASCII_MAX  = 8'h7E;
   localparam logic [7:0] DLB_ASCII_FILL = 8'h20;

   // Reset values of the data path.
   localparam logic [15:0] DLB_RST_WORD = 16'h0000;
   localparam logic [7:0]  DLB_RST_BYTE = 8'h00;

   // Error codes reported with the error pulse.
   localparam logic [1:0] DLB_ERR_NONE  = 2'h0;
   localparam logic [1:0] DLB_ERR_SHORT = 2'h1;
   localparam logic [1:0] DLB_ERR_MODE  = 2'h2;
   localparam logic [1:0] DLB_ERR_ASCII = 2'h3;

   // Transfer modes of a block.
   typedef enum logic [1:0] {
      DLB_MODE_PIO16 = 2'b00,
      DLB_MODE_PIO8  = 2'b01,
      DLB_MODE_DMA   = 2'b10
   } dlb_mode_t;

   // Phases of the data lane sequencer.
   typedef enum logic [1:0] {
      DLB_ST_IDLE = 2'b00,
      DLB_ST_PIO  = 2'b01,
      DLB_ST_DREQ = 2'b10,
      DLB_ST_DBUR = 2'b11
   } dlb_state_t;

   // True when a byte lies in the printable text range.
   function automatic logic dlb_is_print(input logic [7:0] b);
      return (b >= DLB_ASCII_MIN) && (b <= DLB_ASCII_MAX);
   endfunction

endpackage

// ==== logic/dlb_lane_map.sv ====
`timescale 1ns/1ps
// Places bytes onto the data lanes and takes them back off again.
module dlb_lane_map
   import dlb_pkg::*;
(
   // Byte pair to send, first byte in i_b0.
   input  logic [7:0]  i_b0,
   input  logic [7:0]  i_b1,
   // Lane order selection.
   input  logic        i_pio8,
   input  logic        i_ascii,
   // Word received from the bus.
   input  logic [15:0] i_word,
   // Mapped results.
   output logic [15:0] o_word,
   output logic [7:0]  o_first,
   output logic [7:0]  o_second
);

   // Outgoing word: text swaps the lanes, the narrow mode uses the low lane only.
   always_comb begin
      if (i_pio8) begin
         o_word = {DLB_RST_BYTE, i_b0};
      end else if (i_ascii) begin
         o_word = {i_b0, i_b1};
      end else begin
         o_word = {i_b1, i_b0};
      end
   end

   // Incoming word: pick which lane carries the earlier byte.
   always_comb begin
      if (i_ascii && !i_pio8) begin
         o_first  = i_word[15:8];
         o_second = i_word[7:0];
      end else begin
         o_first  = i_word[7:0];
         o_second = i_word[15:8];
      end
   end

endmodule

// ==== tb/dlb_host_model.sv ====
`timescale 1ns/1ps
// Host adapter model: moves bus words and answers DMA requests.
module dlb_host_model (
   // Clock.
   input  logic        i_clk,
   // Device status and bus.
   input  logic        i_occ,
   input  logic        i_req,
   input  logic        i_dma_req,
   input  logic [15:0] i_lines,
   input  logic        i_oe,
   // Host drives.
   output logic        o_strobe,
   output logic        o_ack_n,
   output logic [15:0] o_lines
);
   logic in_burst;

   // Idle host: no strobe and the acknowledge negated.
   initial begin
      o_strobe = 1'b0;
      o_ack_n  = 1'b1;
      o_lines  = 16'h0000;
      in_burst = 1'b0;
   end

   // Waits until a word may move, and for device data when reading.
   task automatic wait_phase(input bit need_oe);
      for (int i = 0; i < 60; i++) begin
         if ((in_burst || (!i_occ && i_req)) && (!need_oe || i_oe)) break;
         @(posedge i_clk);
         #1;
      end
   endtask

   // Reads one full width word.
   task automatic read_word(output logic [15:0] w);
      wait_phase(1'b1);
      w = i_lines;
      o_strobe = 1'b1;
      @(posedge i_clk);
      #1;
      o_strobe = 1'b0;
   endtask

   // Writes one word and keeps a gap cycle; the released bus shows the inverse.
   task automatic write_word(input logic [15:0] w);
      wait_phase(1'b0);
      o_lines  = w;
      o_strobe = 1'b1;
      @(posedge i_clk);
      #1;
      o_strobe = 1'b0;
      o_lines  = ~w;
      @(posedge i_clk);
      #1;
   endtask

   // Opens a burst once the device requests one, or after 60 cycles without a request.
   task automatic dma_open();
      for (int i = 0; i < 60 && !i_dma_req; i++) begin
         @(posedge i_clk);
         #1;
      end
      o_ack_n  = 1'b0;
      in_burst = 1'b1;
      @(posedge i_clk);
      #1;
   endtask

   // Ends the burst by negating the acknowledge.
   task automatic dma_close();
      o_ack_n  = 1'b1;
      in_burst = 1'b0;
      @(posedge i_clk);
      #1;
   endtask
endmodule

// ==== tb/dlb_lane_order_tb.sv ====
`timescale 1ns/1ps
module dlb_lane_order_tb;
   import dlb_pkg::*;

   // Design ports.
   logic        i_clk, i_reset_n, i_blk_start, i_blk_to_host, i_blk_ascii;
   logic [15:0] i_blk_len, i_lines, o_lines;
   dlb_mode_t   i_blk_mode;
   logic [7:0]  i_tx_byte, o_rx_byte;
   logic        i_tx_valid, o_tx_ready, o_rx_valid, o_done, o_err;
   logic [1:0]  o_err_code;
   logic        i_strobe, i_dma_ack_n, o_dma_request, o_occ, o_req, o_oe;
   // Run bookkeeping.
   int          err_count, n_checks, done_cnt, done_exp;
   logic [7:0]  rxq[$];
   logic [1:0]  errq[$];
   // Second device with the narrow mode built in.
   logic        n8_start, n8_strobe, n8_ack_n, n8_rdy, n8_rxv, n8_occ, n8_req, n8_oe;
   logic [15:0] n8_lines, n8_out;
   logic [7:0]  n8_rxb;

   dlb_lane_order #(.P_LEN_W(16), .P_PIO8_EN(1'b0)) DUT (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_blk_start(i_blk_start),
      .i_blk_len(i_blk_len), .i_blk_mode(i_blk_mode), .i_blk_to_host(i_blk_to_host),
      .i_blk_ascii(i_blk_ascii), .i_tx_byte(i_tx_byte), .i_tx_valid(i_tx_valid),
      .o_tx_ready(o_tx_ready), .o_rx_byte(o_rx_byte), .o_rx_valid(o_rx_valid),
      .o_done(o_done), .o_err(o_err), .o_err_code(o_err_code), .i_strobe(i_strobe),
      .i_dma_ack_n(i_dma_ack_n), .o_dma_request(o_dma_request),
      .o_device_occupied_flag(o_occ), .o_transfer_request_flag(o_req),
      .i_parallel_data_lines(i_lines), .o_parallel_data_lines(o_lines),
      .o_parallel_data_lines_oe(o_oe));

   dlb_host_model host (
      .i_clk(i_clk), .i_occ(o_occ), .i_req(o_req), .i_dma_req(o_dma_request),
      .i_lines(o_lines), .i_oe(o_oe), .o_strobe(i_strobe), .o_ack_n(i_dma_ack_n),
      .o_lines(i_lines));

   dlb_lane_order #(.P_LEN_W(16), .P_PIO8_EN(1'b1)) DUT8 (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_blk_start(n8_start),
      .i_blk_len(i_blk_len), .i_blk_mode(i_blk_mode), .i_blk_to_host(i_blk_to_host),
      .i_blk_ascii(i_blk_ascii), .i_tx_byte(i_tx_byte), .i_tx_valid(i_tx_valid),
      .o_tx_ready(n8_rdy), .o_rx_byte(n8_rxb), .o_rx_valid(n8_rxv),
      .o_done(), .o_err(), .o_err_code(), .i_strobe(n8_strobe),
      .i_dma_ack_n(n8_ack_n), .o_dma_request(),
      .o_device_occupied_flag(n8_occ), .o_transfer_request_flag(n8_req),
      .i_parallel_data_lines(n8_lines), .o_parallel_data_lines(n8_out),
      .o_parallel_data_lines_oe(n8_oe));

   dlb_host_model host8 (
      .i_clk(i_clk), .i_occ(n8_occ), .i_req(n8_req), .i_dma_req(1'b0),
      .i_lines(n8_out), .i_oe(n8_oe), .o_strobe(n8_strobe), .o_ack_n(n8_ack_n),
      .o_lines(n8_lines));

   // Clock of 100 ns period.
   initial i_clk = 1'b0;
   always #50 i_clk = ~i_clk;

   // Collects received bytes, error codes and completions.
   always @(posedge i_clk) begin
      if (o_rx_valid) rxq.push_back(o_rx_byte);
      if (n8_rxv) rxq.push_back(n8_rxb);
      if (o_err) errq.push_back(o_err_code);
      if (o_done) done_cnt++;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic start(input logic [15:0] n, input dlb_mode_t m, input logic th, input logic a);
      i_blk_len     = n;
      i_blk_mode    = m;
      i_blk_to_host = th;
      i_blk_ascii   = a;
      i_blk_start   = 1'b1;
      @(posedge i_clk);
      #1;
      i_blk_start = 1'b0;
   endtask

   // Hands n bytes to the device, each held until ready takes it.
   task automatic feed(input logic [31:0] b, input int n);
      for (int k = 0; k < n; k++) begin
         i_tx_byte  = b[8*k +: 8];
         i_tx_valid = 1'b1;
         for (int i = 0; i < 60 && !o_tx_ready; i++) begin
            @(posedge i_clk);
            #1;
         end
         @(posedge i_clk);
         #1;
      end
      i_tx_valid = 1'b0;
   endtask

   // Lets the block end, then checks completion and the error record.
   task automatic settle(input logic inc, input logic [1:0] code);
      repeat (6) @(posedge i_clk);
      #1;
      done_exp += inc;
      chk(16'(done_cnt), 16'(done_exp));
      chk(16'(errq.size()), (code == DLB_ERR_NONE) ? 16'h0000 : 16'h0001);
      if (errq.size() == 1) chk(16'(errq[0]), 16'(code));
      errq.delete();
   endtask

   task automatic chk_rx(input logic [31:0] b, input int n);
      chk(16'(rxq.size()), 16'(n));
      for (int k = 0; k < n && k < rxq.size(); k++) chk(16'(rxq[k]), 16'(b[8*k +: 8]));
      rxq.delete();
   endtask

   // Device to host block; expected words packed low word first.
   task automatic rd_blk(input dlb_mode_t m, input logic a, input logic [15:0] n,
                         input logic [31:0] b, input logic [31:0] ew, input logic [1:0] code);
      logic [15:0] w;
      start(n, m, 1'b1, a);
      fork
         feed(b, int'(n));
         begin
            if (m == DLB_MODE_DMA) host.dma_open();
            for (int k = 0; k < (n + 1) / 2; k++) begin
               host.read_word(w);
               chk(w, ew[16*k +: 16]);
            end
            if (m == DLB_MODE_DMA) host.dma_close();
         end
      join
      settle(1'b1, code);
   endtask

   // Host to device block of up to two words.
   task automatic wr_blk(input dlb_mode_t m, input logic a, input logic [15:0] n,
                         input logic [31:0] ws);
      start(n, m, 1'b0, a);
      if (m == DLB_MODE_DMA) host.dma_open();
      for (int k = 0; k < (n + 1) / 2; k++) host.write_word(ws[16*k +: 16]);
      if (m == DLB_MODE_DMA) host.dma_close();
      settle(1'b1, DLB_ERR_NONE);
   endtask

   // Starts that must be refused.
   task automatic s_refused();
      start(16'h0000, DLB_MODE_PIO16, 1'b1, 1'b0);
      settle(1'b0, DLB_ERR_MODE);
      start(16'h0002, DLB_MODE_PIO8, 1'b1, 1'b0);
      settle(1'b0, DLB_ERR_MODE);
      start(16'h0001, DLB_MODE_DMA, 1'b1, 1'b0);
      settle(1'b0, DLB_ERR_MODE);
   endtask

   // Odd read: last byte alone on the low lane.
   task automatic s_pio_read();
      rd_blk(DLB_MODE_PIO16, 1'b0, 16'h0003, 32'h00C3_B2A1, 32'h00C3_B2A1, DLB_ERR_NONE);
   endtask

   // Text read: earlier character high, bad code replaced by a space.
   task automatic s_text_read();
      rd_blk(DLB_MODE_PIO16, 1'b1, 16'h0004, 32'h7907_6F43, 32'h2079_436F, DLB_ERR_ASCII);
   endtask

   task automatic s_dma_read();
      rd_blk(DLB_MODE_DMA, 1'b0, 16'h0004, 32'h4433_2211, 32'h4433_2211, DLB_ERR_NONE);
   endtask

   // Writes: odd block, then a text word.
   task automatic s_writes();
      wr_blk(DLB_MODE_PIO16, 1'b0, 16'h0003, 32'h9966_5544);
      chk_rx(32'h0066_5544, 3);
      wr_blk(DLB_MODE_PIO16, 1'b1, 16'h0002, 32'h0000_436F);
      chk_rx(32'h0000_6F43, 2);
   endtask

   // An empty burst is flagged, then a proper burst finishes the block.
   task automatic s_dma_short();
      start(16'h0002, DLB_MODE_DMA, 1'b0, 1'b0);
      host.dma_open();
      host.dma_close();
      host.dma_open();
      host.write_word(16'hBBAA);
      host.dma_close();
      settle(1'b1, DLB_ERR_SHORT);
      chk_rx(32'h0000_BBAA, 2);
   endtask

   // Pulses the start of the narrow-mode device for a two-byte block.
   task automatic start8(input logic th);
      i_blk_len     = 16'h0002;
      i_blk_mode    = DLB_MODE_PIO8;
      i_blk_to_host = th;
      i_blk_ascii   = 1'b0;
      n8_start      = 1'b1;
      @(posedge i_clk);
      #1;
      n8_start = 1'b0;
   endtask

   // Narrow mode: one byte per word on lanes 7 to 0, read and then write.
   task automatic s_pio8();
      logic [15:0] w;
      start8(1'b1);
      fork
         begin
            for (int k = 0; k < 2; k++) begin
               i_tx_byte  = k ? 8'hA5 : 8'h5A;
               i_tx_valid = 1'b1;
               for (int i = 0; i < 60 && !n8_rdy; i++) begin
                  @(posedge i_clk);
                  #1;
               end
               @(posedge i_clk);
               #1;
            end
            i_tx_valid = 1'b0;
         end
         begin
            host8.read_word(w);
            chk(w, 16'h005A);
            host8.read_word(w);
            chk(w, 16'h00A5);
         end
      join
      repeat (6) @(posedge i_clk);
      #1;
      start8(1'b0);
      host8.write_word(16'hEE11);
      host8.write_word(16'hDD22);
      repeat (6) @(posedge i_clk);
      #1;
      chk_rx(32'h0000_2211, 2);
   endtask

   // Reset for six cycles, then the scenarios.
   initial begin
      i_reset_n     = 1'b0;
      i_blk_start   = 1'b0;
      i_blk_len     = 16'h0000;
      i_blk_mode    = DLB_MODE_PIO16;
      i_blk_to_host = 1'b0;
      i_blk_ascii   = 1'b0;
      i_tx_byte     = 8'h00;
      i_tx_valid    = 1'b0;
      n8_start      = 1'b0;
      repeat (6) @(posedge i_clk);
      #1;
      chk({12'h000, o_occ, o_req, o_dma_request, o_oe}, 16'h0000);
      i_reset_n = 1'b1;
      s_refused();
      s_pio_read();
      s_text_read();
      s_dma_read();
      s_writes();
      s_dma_short();
      s_pio8();
      stop_test();
   end

   // Cuts a hung run short; the tests need well under 3000 cycles.
   initial begin
      #(100 * 3000);
      err_count++;
      stop_test();
   end
endmodule
